/* File: src/vpc_i2c_slave.sv */
// serial two-wire slave that turns bus traffic into byte events
`timescale 1ns/1ps
`include "vpc_params.svh"

module vpc_i2c_slave
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] rd_byte,
  output vpc_pkg::vpc_bus_ev_t bus_ev
);

  vpc_pkg::vpc_state_t state_reg, state_next;
  logic scl_reg, scl_next, sda_reg, sda_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rw_reg, rw_next, first_reg, first_next, ackd_reg, ackd_next, oe_reg, oe_next;
  vpc_pkg::vpc_bus_ev_t ev_reg, ev_next;
  logic rise, fall, start, stop;

  // line conditions; start and stop are sda moves while scl stays high
  assign rise = scl_in && !scl_reg;
  assign fall = !scl_in && scl_reg;
  assign start = scl_in && scl_reg && sda_reg && !sda_in;
  assign stop = scl_in && scl_reg && !sda_reg && sda_in;

  // byte engine; data changes on the falling edge and is sampled on the rising one
  always_comb
  begin
    state_next = state_reg;
    scl_next = scl_in;
    sda_next = sda_in;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    ackd_next = ackd_reg;
    oe_next = oe_reg;
    ev_next = '0;
    ev_next.data = ev_reg.data;
    if (start)
    begin
      state_next = vpc_pkg::VPC_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end
    else if (stop)
    begin
      state_next = vpc_pkg::VPC_IDLE;
      oe_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        vpc_pkg::VPC_IDLE: ;
        vpc_pkg::VPC_ADDR, vpc_pkg::VPC_WDATA:
        begin
          if (rise)
          begin
            sh_next = {sh_reg[6:0], sda_in};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (fall && cnt_reg == `VPC_BITS_PER_BYTE)
          begin
            if (state_reg == vpc_pkg::VPC_ADDR)
            begin
              // only our own address is acknowledged
              state_next = (sh_reg[7:1] == `VPC_SLAVE_ADDR) ? vpc_pkg::VPC_AACK : vpc_pkg::VPC_IDLE;
              oe_next = (sh_reg[7:1] == `VPC_SLAVE_ADDR);
              rw_next = sh_reg[0];
            end
            else
            begin
              state_next = vpc_pkg::VPC_WACK;
              oe_next = 1'b1;
              ev_next.index_wr = first_reg;
              ev_next.data_wr = !first_reg;
              ev_next.data = sh_reg;
              first_next = 1'b0;
            end
          end
        end
        vpc_pkg::VPC_AACK, vpc_pkg::VPC_WACK:
        begin
          if (fall)
          begin
            cnt_next = 4'h0;
            if (state_reg == vpc_pkg::VPC_AACK && rw_reg)
            begin
              state_next = vpc_pkg::VPC_RDATA;
              sh_next = rd_byte;
              oe_next = !rd_byte[7];
            end
            else
            begin
              state_next = vpc_pkg::VPC_WDATA;
              oe_next = 1'b0;
              first_next = (state_reg == vpc_pkg::VPC_AACK) ? 1'b1 : first_reg;
            end
          end
        end
        vpc_pkg::VPC_RDATA:
        begin
          if (fall)
          begin
            cnt_next = cnt_reg + 4'h1;
            sh_next = {sh_reg[6:0], 1'b0};
            oe_next = (cnt_reg == 4'h7) ? 1'b0 : !sh_reg[6];
            state_next = (cnt_reg == 4'h7) ? vpc_pkg::VPC_RACK : vpc_pkg::VPC_RDATA;
          end
        end
        vpc_pkg::VPC_RACK:
        begin
          if (rise)
          begin
            ackd_next = !sda_in;
            ev_next.rd_advance = !sda_in;
          end
          else if (fall)
          begin
            cnt_next = 4'h0;
            state_next = ackd_reg ? vpc_pkg::VPC_RDATA : vpc_pkg::VPC_IDLE;
            sh_next = rd_byte;
            oe_next = ackd_reg && !rd_byte[7];
          end
        end
        default:
        begin
          state_next = vpc_pkg::VPC_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // registers of the byte engine
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= vpc_pkg::VPC_IDLE;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      ackd_reg <= 1'b0;
      oe_reg <= 1'b0;
      ev_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      rw_reg <= rw_next;
      first_reg <= first_next;
      ackd_reg <= ackd_next;
      oe_reg <= oe_next;
      ev_reg <= ev_next;
    end
  end

  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe = oe_reg;
  assign bus_ev = ev_reg;

  // an address acknowledge is given only after our own address
  addr_ack_only_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_reg == vpc_pkg::VPC_ADDR && state_next == vpc_pkg::VPC_AACK |-> sh_reg[7:1] == `VPC_SLAVE_ADDR)
    else $error("address acknowledged for a foreign slave");

endmodule

/* File: src/vpc_params.svh */
// constants of the video pre-amp control register bank
`ifndef VPC_PARAMS_SVH
`define VPC_PARAMS_SVH

// register indices
`define VPC_ADDR_DAC3 8'h06
`define VPC_ADDR_PIN_SELECT_A 8'h07
`define VPC_ADDR_OFS 8'h08
`define VPC_ADDR_GCTL 8'h09
`define VPC_ADDR_AUTO_INCREMENT_DISABLE 8'h0a
`define VPC_ADDR_CBO 8'h0b
`define VPC_ADDR_SOFT_RESET_TRIGGER 8'h0f

// reset values
`define VPC_RST_DAC3 8'h80
`define VPC_RST_PIN_SELECT_A 8'h80
`define VPC_RST_OFS 8'h15
`define VPC_RST_GCTL 8'h00
`define VPC_RST_AUTO_INCREMENT_DISABLE 8'h00
`define VPC_RST_CBO 8'h04
`define VPC_RST_SOFT_RESET_TRIGGER 8'h00

// storable bits per register, reserved bits read zero
`define VPC_MASK_OFS 8'h1f
`define VPC_MASK_GCTL 8'h3f
`define VPC_MASK_AUTO_INCREMENT_DISABLE 8'h03
`define VPC_MASK_CBO 8'h0f
`define VPC_SOFT_RESET_TRIGGER_BIT 0

// bus slave address, write 0xdc and read 0xdd
`define VPC_SLAVE_ADDR 7'h6e
`define VPC_BITS_PER_BYTE 4'h8

`endif

/* File: src/vpc_pkg.sv */
// types of the video pre-amp control register bank
package vpc_pkg;

  typedef struct packed {
    logic [2:0] rsv;
    logic [1:0] overlay_contrast_level;
    logic [2:0] black_shift_level;
  } vpc_ofs_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic must_zero_hi;
    logic pin_select_a_mix_enable;
    logic dac_half_range;
    logic must_zero_lo;
    logic sleep_request;
    logic video_blank;
  } vpc_gctl_t;

  typedef struct packed {
    logic [5:0] rsv;
    logic must_zero;
    logic auto_increment_disable;
  } vpc_auto_increment_disable_t;

  typedef struct packed {
    logic [3:0] rsv;
    logic clamp_polarity;
    logic pin_select_a;
    logic vblank_enable;
    logic overlay_only;
  } vpc_cbo_t;

  // one-cycle events from the serial slave
  typedef struct packed {
    logic index_wr;
    logic data_wr;
    logic rd_advance;
    logic [7:0] data;
  } vpc_bus_ev_t;

  // controls applied to the analog side
  typedef struct packed {
    logic [7:0] third_dac_level;
    logic [7:0] fourth_dac_level;
    logic [2:0] black_shift_level;
    logic [1:0] overlay_contrast_level;
    logic sleep_request;
    logic dac_half_range;
    logic pin_select_a_mix_enable;
    logic pin_select_a;
    logic clamp_polarity;
    logic overlay_only;
  } vpc_ctl_t;

  typedef enum logic [2:0] {
    VPC_IDLE = 3'b000,
    VPC_ADDR = 3'b001,
    VPC_AACK = 3'b010,
    VPC_WDATA = 3'b011,
    VPC_WACK = 3'b100,
    VPC_RDATA = 3'b101,
    VPC_RACK = 3'b110
  } vpc_state_t;

endpackage

/* File: src/vpc_regs.sv */
// video pre-amp control register bank behind the serial slave
`timescale 1ns/1ps
`include "vpc_params.svh"

module vpc_regs
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic hblank_in,
  input wire logic vblank_pin_in,
  input wire logic sandcastle_vblank_in,
  output vpc_pkg::vpc_ctl_t ctl,
  output logic video_blank_out
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] idx_reg, idx_next;
  logic [7:0] dac3_reg, dac3_next, pin_select_a_reg, pin_select_a_next;
  vpc_pkg::vpc_ofs_t ofs_reg, ofs_next;
  vpc_pkg::vpc_gctl_t gctl_reg, gctl_next;
  vpc_pkg::vpc_auto_increment_disable_t auto_increment_disable_reg, auto_increment_disable_next;
  vpc_pkg::vpc_cbo_t cbo_reg, cbo_next;
  logic soft_reset_trigger_reg, soft_reset_trigger_next;
  vpc_pkg::vpc_ctl_t ctl_reg, ctl_next;
  logic blank_reg, blank_next;
  vpc_pkg::vpc_bus_ev_t bus_ev;
  logic [7:0] rd_byte;
  logic vblank_active, step_idx;

  // ****************************************************************
  // serial slave
  // ****************************************************************
  vpc_i2c_slave u_slave
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .rd_byte(rd_byte),
    .bus_ev(bus_ev)
  );

  // vertical blank source: sandcastle while the dac pin is an output, else the pin
  assign vblank_active = cbo_reg.pin_select_a ? sandcastle_vblank_in : vblank_pin_in;
  assign step_idx = (bus_ev.data_wr || bus_ev.rd_advance) && !auto_increment_disable_reg.auto_increment_disable;

  // read data for the current index; holes and reserved bits read zero
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (idx_reg)
      `VPC_ADDR_DAC3: rd_byte = dac3_reg;
      `VPC_ADDR_PIN_SELECT_A: rd_byte = pin_select_a_reg;
      `VPC_ADDR_OFS: rd_byte = ofs_reg;
      `VPC_ADDR_GCTL: rd_byte = gctl_reg;
      `VPC_ADDR_AUTO_INCREMENT_DISABLE: rd_byte = auto_increment_disable_reg;
      `VPC_ADDR_CBO: rd_byte = cbo_reg;
      `VPC_ADDR_SOFT_RESET_TRIGGER: rd_byte = {7'h00, soft_reset_trigger_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  // ****************************************************************
  // register writes, index and software reset
  // ****************************************************************
  always_comb
  begin
    idx_next = idx_reg;
    dac3_next = dac3_reg;
    pin_select_a_next = pin_select_a_reg;
    ofs_next = ofs_reg;
    gctl_next = gctl_reg;
    auto_increment_disable_next = auto_increment_disable_reg;
    cbo_next = cbo_reg;
    soft_reset_trigger_next = soft_reset_trigger_reg;
    // the index belongs to the bus transfer and survives a software reset
    if (bus_ev.index_wr)
    begin
      idx_next = bus_ev.data;
    end
    else if (step_idx)
    begin
      idx_next = idx_reg + 8'h01;
    end
    if (soft_reset_trigger_reg)
    begin
      // one cycle of reload, then the trigger drops by itself
      dac3_next = `VPC_RST_DAC3;
      pin_select_a_next = `VPC_RST_PIN_SELECT_A;
      ofs_next = vpc_pkg::vpc_ofs_t'(`VPC_RST_OFS);
      gctl_next = vpc_pkg::vpc_gctl_t'(`VPC_RST_GCTL);
      auto_increment_disable_next = vpc_pkg::vpc_auto_increment_disable_t'(`VPC_RST_AUTO_INCREMENT_DISABLE);
      cbo_next = vpc_pkg::vpc_cbo_t'(`VPC_RST_CBO);
      soft_reset_trigger_next = 1'b0;
    end
    else if (bus_ev.data_wr)
    begin
      unique case (idx_reg)
        `VPC_ADDR_DAC3: dac3_next = bus_ev.data;
        `VPC_ADDR_PIN_SELECT_A: pin_select_a_next = bus_ev.data;
        `VPC_ADDR_OFS: ofs_next = vpc_pkg::vpc_ofs_t'(bus_ev.data & `VPC_MASK_OFS);
        `VPC_ADDR_GCTL: gctl_next = vpc_pkg::vpc_gctl_t'(bus_ev.data & `VPC_MASK_GCTL);
        `VPC_ADDR_AUTO_INCREMENT_DISABLE: auto_increment_disable_next = vpc_pkg::vpc_auto_increment_disable_t'(bus_ev.data & `VPC_MASK_AUTO_INCREMENT_DISABLE);
        `VPC_ADDR_CBO: cbo_next = vpc_pkg::vpc_cbo_t'(bus_ev.data & `VPC_MASK_CBO);
        `VPC_ADDR_SOFT_RESET_TRIGGER: soft_reset_trigger_next = bus_ev.data[`VPC_SOFT_RESET_TRIGGER_BIT];
        default: ;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idx_reg <= 8'h00;
      dac3_reg <= `VPC_RST_DAC3;
      pin_select_a_reg <= `VPC_RST_PIN_SELECT_A;
      ofs_reg <= vpc_pkg::vpc_ofs_t'(`VPC_RST_OFS);
      gctl_reg <= vpc_pkg::vpc_gctl_t'(`VPC_RST_GCTL);
      auto_increment_disable_reg <= vpc_pkg::vpc_auto_increment_disable_t'(`VPC_RST_AUTO_INCREMENT_DISABLE);
      cbo_reg <= vpc_pkg::vpc_cbo_t'(`VPC_RST_CBO);
      soft_reset_trigger_reg <= 1'b0;
    end
    else
    begin
      idx_reg <= idx_next;
      dac3_reg <= dac3_next;
      pin_select_a_reg <= pin_select_a_next;
      ofs_reg <= ofs_next;
      gctl_reg <= gctl_next;
      auto_increment_disable_reg <= auto_increment_disable_next;
      cbo_reg <= cbo_next;
      soft_reset_trigger_reg <= soft_reset_trigger_next;
    end
  end

  // ****************************************************************
  // applied controls and output blanking
  // ****************************************************************
  // contrast and fourth dac wait for retrace while vblank_enable is set; a software reset applies them at once
  always_comb
  begin
    ctl_next = ctl_reg;
    ctl_next.third_dac_level = dac3_reg;
    ctl_next.black_shift_level = ofs_reg.black_shift_level;
    ctl_next.sleep_request = gctl_reg.sleep_request;
    ctl_next.dac_half_range = gctl_reg.dac_half_range;
    ctl_next.pin_select_a_mix_enable = gctl_reg.pin_select_a_mix_enable;
    ctl_next.pin_select_a = cbo_reg.pin_select_a;
    ctl_next.clamp_polarity = cbo_reg.clamp_polarity;
    ctl_next.overlay_only = cbo_reg.overlay_only;
    if (soft_reset_trigger_reg || !cbo_reg.vblank_enable || vblank_active)
    begin
      ctl_next.fourth_dac_level = pin_select_a_reg;
      ctl_next.overlay_contrast_level = ofs_reg.overlay_contrast_level;
    end
    blank_next = gctl_reg.video_blank || cbo_reg.overlay_only || hblank_in
      || (cbo_reg.vblank_enable && vblank_active);
  end

  // output flops
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_reg <= '0;
      blank_reg <= 1'b0;
    end
    else
    begin
      ctl_reg <= ctl_next;
      blank_reg <= blank_next;
    end
  end

  assign ctl = ctl_reg;
  assign video_blank_out = blank_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence soft_reset_trigger_write_s;
    bus_ev.data_wr && idx_reg == `VPC_ADDR_SOFT_RESET_TRIGGER && bus_ev.data[0] && !soft_reset_trigger_reg;
  endsequence

  sequence soft_reset_trigger_run_s;
    soft_reset_trigger_reg ##1 (!soft_reset_trigger_reg && cbo_reg == vpc_pkg::vpc_cbo_t'(`VPC_RST_CBO)
      && gctl_reg == vpc_pkg::vpc_gctl_t'(`VPC_RST_GCTL) && pin_select_a_reg == `VPC_RST_PIN_SELECT_A);
  endsequence

  soft_reset_trigger_self_clear_a: assert property (soft_reset_trigger_write_s |=> soft_reset_trigger_run_s)
    else $error("software reset did not reload and clear");

  idx_step_a: assert property (bus_ev.data_wr && !auto_increment_disable_reg.auto_increment_disable
    |=> idx_reg == $past(idx_reg) + 8'h01)
    else $error("index did not advance after a data byte");

  idx_hold_a: assert property (bus_ev.data_wr && auto_increment_disable_reg.auto_increment_disable
    |=> $stable(idx_reg))
    else $error("index moved with increment disabled");

  pin_select_a_hold_a: assert property (cbo_reg.vblank_enable && !vblank_active && !soft_reset_trigger_reg
    |=> $stable(ctl.fourth_dac_level))
    else $error("fourth dac changed outside retrace");

  pin_select_a_apply_a: assert property (!cbo_reg.vblank_enable && !soft_reset_trigger_reg
    |=> ctl.fourth_dac_level == $past(pin_select_a_reg))
    else $error("fourth dac not applied at once");

  blank_force_a: assert property (gctl_reg.video_blank || cbo_reg.overlay_only
    |=> video_blank_out)
    else $error("video not blanked");

  vbl_or_a: assert property (!gctl_reg.video_blank && !cbo_reg.overlay_only && !hblank_in
    |=> video_blank_out == $past(cbo_reg.vblank_enable && vblank_active))
    else $error("vertical blank not ored correctly");

  dac3_write_a: assert property (bus_ev.data_wr && idx_reg == `VPC_ADDR_DAC3 && !soft_reset_trigger_reg
    |=> dac3_reg == $past(bus_ev.data) ##1 ctl.third_dac_level == $past(bus_ev.data, 2))
    else $error("third dac write not applied");

  gctl_follow_a: assert property (1'b1 |=> ctl.sleep_request == $past(gctl_reg.sleep_request)
    && ctl.dac_half_range == $past(gctl_reg.dac_half_range)
    && ctl.pin_select_a_mix_enable == $past(gctl_reg.pin_select_a_mix_enable))
    else $error("global controls not applied");

  // stored fields, index moves, reserved bits and applied outputs; a bad mask would leak into the analog side
  pin_select_a_write_a: assert property (bus_ev.data_wr && idx_reg == `VPC_ADDR_PIN_SELECT_A && !soft_reset_trigger_reg
    |=> pin_select_a_reg == $past(bus_ev.data))
    else $error("fourth dac write not stored");

  ofs_write_a: assert property (bus_ev.data_wr && idx_reg == `VPC_ADDR_OFS && !soft_reset_trigger_reg
    |=> ofs_reg == ($past(bus_ev.data) & `VPC_MASK_OFS))
    else $error("offset register write not stored");

  rsv_zero_a: assert property (ofs_reg.rsv == 3'h0 && gctl_reg.rsv == 2'h0
    && auto_increment_disable_reg.rsv == 6'h00 && cbo_reg.rsv == 4'h0)
    else $error("reserved bits hold a one");

  shift_follow_a: assert property (1'b1
    |=> ctl.black_shift_level == $past(ofs_reg.black_shift_level))
    else $error("black shift not applied");

  ovl_hold_a: assert property (cbo_reg.vblank_enable && !vblank_active && !soft_reset_trigger_reg
    |=> $stable(ctl.overlay_contrast_level))
    else $error("overlay contrast changed outside retrace");

  ovl_apply_a: assert property (!cbo_reg.vblank_enable && !soft_reset_trigger_reg
    |=> ctl.overlay_contrast_level == $past(ofs_reg.overlay_contrast_level))
    else $error("overlay contrast not applied at once");

  cbo_follow_a: assert property (1'b1 |=> ctl.pin_select_a == $past(cbo_reg.pin_select_a)
    && ctl.clamp_polarity == $past(cbo_reg.clamp_polarity)
    && ctl.overlay_only == $past(cbo_reg.overlay_only))
    else $error("clamp and overlay controls not applied");

  idx_load_a: assert property (bus_ev.index_wr
    |=> idx_reg == $past(bus_ev.data))
    else $error("index byte not loaded");

  rd_step_a: assert property (bus_ev.rd_advance && !auto_increment_disable_reg.auto_increment_disable
    |=> idx_reg == $past(idx_reg) + 8'h01)
    else $error("index did not advance after a read byte");

  hblank_pass_a: assert property (hblank_in
    |=> video_blank_out)
    else $error("horizontal blank not passed");

endmodule

/* File: verification/vpc_i2c_master.sv */
// two-wire bus master model that drives the register bank's serial port
`timescale 1ns/1ps

// ********************************
// bus master
// ********************************
module vpc_i2c_master
(
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // idle bus: clock high, data released to its pull-up
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // four clocks a phase, above the slave's two-clock minimum
  task automatic hold();
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // data falls while the clock is high; also serves as repeated start
  task automatic start();
    sda_pull = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_pull = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_pull = 1'b0;
    hold();
  endtask

  // data set in the low phase and held across the whole high phase
  task automatic bit_io(input logic b, output logic s);
    sda_pull = ~b;
    hold();
    scl = 1'b1;
    hold();
    s = sda_line;
    scl = 1'b0;
    hold();
  endtask

  // msb first; ack high when the slave pulled the line low
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // more high answers ack to ask for the next byte, low ends the read
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~more, s);
  endtask
endmodule

/* File: verification/vpc_regs_bench.sv */
// self-checking bench for the video pre-amp control register bank
`timescale 1ns/1ps

module vpc_regs_bench;
  logic core_clk, rst_b, scl, sda_pull, sda_out, sda_oe;
  logic hblank_in, vblank_pin_in, sandcastle_vblank_in, video_blank_out;
  logic sda_line;
  vpc_pkg::vpc_ctl_t ctl;
  int fail_count, n_compared, cycles;
  logic [7:0] mdl [0:15];
  logic [7:0] bq [$];
  logic [7:0] rq [$];
  logic [7:0] keep;

  // open-drain wire with a pull-up
  assign sda_line = !((sda_oe && !sda_out) || sda_pull);

  vpc_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .hblank_in(hblank_in), .vblank_pin_in(vblank_pin_in),
    .sandcastle_vblank_in(sandcastle_vblank_in), .ctl(ctl), .video_blank_out(video_blank_out));
  vpc_i2c_master i_master (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // ********************************
  // clock, timeout and reporting
  // ********************************
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // whole run needs about 16k cycles; a hung bus ends it here
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ********************************
  // expectations
  // ********************************
  function automatic logic [7:0] msk(input int idx);
    case (idx)
      6, 7: return 8'hff;
      8: return 8'h1f;
      9: return 8'h3f;
      10: return 8'h03;
      11: return 8'h0f;
      default: return 8'h00;
    endcase
  endfunction

  task automatic set_dflt();
    foreach (mdl[i])
      mdl[i] = 8'h00;
    mdl[6] = 8'h80;
    mdl[7] = 8'h80;
    mdl[8] = 8'h15;
    mdl[11] = 8'h04;
  endtask

  function automatic logic blank_exp();
    return mdl[9][0] | mdl[11][0] | hblank_in | (mdl[11][1] & (mdl[11][2] ? sandcastle_vblank_in : vblank_pin_in));
  endfunction

  // ********************************
  // bus and check tasks
  // ********************************
  task automatic wr(input logic [7:0] idx);
    logic a;
    i_master.start();
    i_master.put_byte(8'hdc, a);
    chk({7'h0, a}, 8'h01);
    i_master.put_byte(idx, a);
    foreach (bq[i])
      i_master.put_byte(bq[i], a);
    i_master.stop();
  endtask

  task automatic rd(input logic [7:0] idx, input int n);
    logic a;
    logic [7:0] d;
    bq = {};
    wr(idx);
    i_master.start();
    i_master.put_byte(8'hdd, a);
    chk({7'h0, a}, 8'h01);
    rq = {};
    for (int i = 0; i < n; i++)
    begin
      i_master.get_byte(i < n - 1, d);
      rq.push_back(d);
    end
    i_master.stop();
  endtask

  // 0x06 up to 0x0f in one burst, unmapped and reserved reading zero
  task automatic readall();
    rd(8'h06, 10);
    foreach (rq[i])
      chk(rq[i], mdl[6 + i]);
  endtask

  task automatic ctl_chk();
    chk(ctl.third_dac_level, mdl[6]);
    chk(ctl.fourth_dac_level, mdl[7]);
    chk({5'h0, ctl.black_shift_level}, {5'h0, mdl[8][2:0]});
    chk({6'h0, ctl.overlay_contrast_level}, {6'h0, mdl[8][4:3]});
    chk({4'h0, ctl.sleep_request, ctl.dac_half_range, ctl.pin_select_a_mix_enable, ctl.pin_select_a},
      {4'h0, mdl[9][1], mdl[9][3], mdl[9][4], mdl[11][2]});
    chk({6'h0, ctl.clamp_polarity, ctl.overlay_only}, {6'h0, mdl[11][3], mdl[11][0]});
  endtask

  // random blanking inputs; output follows one cycle later
  task automatic vid(input int n);
    logic e;
    @(posedge core_clk);
    #1;
    {hblank_in, vblank_pin_in, sandcastle_vblank_in} = 3'($urandom);
    e = blank_exp();
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      chk({7'h0, video_blank_out}, {7'h0, e});
      {hblank_in, vblank_pin_in, sandcastle_vblank_in} = 3'($urandom);
      e = blank_exp();
    end
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    rst_b = 1'b0;
    {hblank_in, vblank_pin_in, sandcastle_vblank_in} = 3'b000;
    void'($urandom(93));
    set_dflt();
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge core_clk);
    readall();
    ctl_chk();
    vid(30);
    // random block writes; must-zero bits and vblank_enable kept clear
    repeat (3)
    begin
      bq = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom) & 8'hdb, 8'h00, 8'($urandom) & 8'h0d};
      wr(8'h06);
      foreach (bq[i])
        mdl[6 + i] = bq[i] & msk(6 + i);
      readall();
      ctl_chk();
      vid(40);
    end
    // vertical blank from the pin and from the sandcastle, clamp positive
    for (int k = 0; k < 2; k++)
    begin
      bq = {8'h00, 8'h00, (k == 1) ? 8'h06 : 8'h02};
      wr(8'h09);
      mdl[9] = 8'h00;
      mdl[10] = 8'h00;
      mdl[11] = bq[2];
      vid(60);
    end
    // retrace hold: new fourth dac level waits for vertical blank
    sandcastle_vblank_in = 1'b0;
    keep = mdl[7];
    mdl[7] = ~keep;
    bq = {mdl[7]};
    wr(8'h07);
    chk(ctl.fourth_dac_level, keep);
    sandcastle_vblank_in = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(ctl.fourth_dac_level, mdl[7]);
    // fixed index: three bytes all land in 0x06
    bq = {8'h04};
    wr(8'h0b);
    bq = {8'h01};
    wr(8'h0a);
    mdl[11] = 8'h04;
    mdl[10] = 8'h01;
    bq = {8'h11, 8'h22, 8'h33};
    wr(8'h06);
    mdl[6] = 8'h33;
    rd(8'h06, 2);
    chk(rq[0], mdl[6]);
    chk(rq[1], mdl[6]);
    bq = {8'h00};
    wr(8'h0a);
    mdl[10] = 8'h00;
    // unmapped write ignored, foreign address left unanswered
    bq = {8'h5a};
    wr(8'h0c);
    i_master.start();
    i_master.put_byte(8'hde, keep[0]);
    chk({7'h0, keep[0]}, 8'h00);
    i_master.stop();
    readall();
    ctl_chk();
    // software reset brings every register back and clears itself
    bq = {8'h01};
    wr(8'h0f);
    set_dflt();
    readall();
    ctl_chk();
    vid(20);
    wrap_up();
  end
endmodule
